// ### cbtrs_can_node.sv
// remote bus node that sends standard data frames and watches the ack slot
// assumes the bench wires the bus as node_tx and the device's tx combined
`timescale 1ns/1ps
module cbtrs_can_node (
  input  wire logic clk,
  input  wire logic can_bus,
  output logic      node_tx,
  output logic      ack_seen
);
  int bit_clks = 36;

  initial node_tx = 1'b1;
  initial ack_seen = 1'b0;

  task automatic put_bit(input logic b);
    @(posedge clk);
    node_tx <= b;
    repeat (bit_clks - 1) @(posedge clk);
  endtask

  task automatic send(input logic [10:0] id, input logic [3:0] dlc,
                      input logic [63:0] data, input bit bad_crc);
    logic        q[$];
    logic        s[$];
    logic [14:0] crc;
    logic        fb;
    logic        last;
    int          run;
    int          nb;
    nb = (dlc > 4'h8) ? 8 : int'(dlc);
    q.push_back(1'b0);
    for (int i = 10; i >= 0; i--) q.push_back(id[i]);
    repeat (3) q.push_back(1'b0); // data frame, standard format
    for (int i = 3; i >= 0; i--) q.push_back(dlc[i]);
    for (int i = 0; i < nb * 8; i++) q.push_back(data[63 - i]);
    crc = '0;
    foreach (q[i]) begin
      fb = q[i] ^ crc[14];
      crc = {crc[13:0], 1'b0} ^ (fb ? cbtrs_pkg::CRC_POLY : 15'h0000);
    end
    crc[0] = crc[0] ^ bad_crc;
    for (int i = 14; i >= 0; i--) q.push_back(crc[i]);
    run = 0;
    last = 1'b1;
    foreach (q[i]) begin
      s.push_back(q[i]);
      run = (q[i] == last) ? run + 1 : 1;
      last = q[i];
      if (run == 5) begin
        s.push_back(~last);
        last = ~last;
        run = 1;
      end
    end
    ack_seen = 1'b0;
    // idle long enough for the receiver to join after leaving reset mode
    repeat (14) put_bit(1'b1);
    foreach (s[i]) put_bit(s[i]);
    put_bit(1'b1);
    @(posedge clk);
    node_tx <= 1'b1;
    repeat (bit_clks / 2) @(posedge clk);
    ack_seen = ~can_bus;
    repeat (bit_clks - 1 - bit_clks / 2) @(posedge clk);
    repeat (11) put_bit(1'b1);
  endtask
endmodule // cbtrs_can_node

// ### cbtrs_pkg.sv
// constants, types and register map of the bit-timing and receive block
// assumes a 32-bit classic wishbone master and a 100 MHz CLK
package cbtrs_pkg;
  localparam logic [11:0] OFF_MODE      = 12'h000;
  localparam logic [11:0] OFF_TIMING_UP = 12'h004;
  localparam logic [11:0] OFF_TIMING_LO = 12'h008;
  localparam logic [11:0] OFF_STATUS    = 12'h00C;
  localparam logic [11:0] OFF_PEND      = 12'h010;
  localparam logic [11:0] OFF_PEND_CLR  = 12'h014;
  localparam logic [11:0] OFF_IRQ_EN    = 12'h018;
  localparam logic [11:0] OFF_MASK      = 12'h01C;
  localparam logic [11:0] OFF_MB_BASE   = 12'h100;
  // word index inside a 32-byte mailbox slot
  localparam logic [2:0]  MBW_ID  = 3'h0;
  localparam logic [2:0]  MBW_CFG = 3'h1;
  localparam logic [2:0]  MBW_DLO = 3'h2;
  localparam logic [2:0]  MBW_DHI = 3'h3;
  localparam int          FIRST_SEGMENT_LENGTH_LSB = 12;
  localparam int          SECOND_SEGMENT_LENGTH_LSB = 8;
  localparam int          SJW_LSB   = 4;
  localparam int          DIR_LSB   = 8;
  localparam logic [15:0] TIMING_UP_RST = 16'h9600;
  localparam logic [7:0]  PRESCALE_RST  = 8'h00;
  localparam logic        MODE_RST      = 1'b1;
  localparam logic [2:0]  DIR_TX = 3'h0;
  localparam logic [2:0]  DIR_RX = 3'h2;
  localparam logic [3:0]  IDLE_BITS = 4'hB;
  localparam logic [6:0]  HDR_LAST  = 7'h11;
  localparam logic [6:0]  CRC_LAST  = 7'h0E;
  localparam logic [6:0]  TAIL_LAST = 7'h09;
  localparam logic [6:0]  ACK_SLOT  = 7'h01;
  localparam logic [2:0]  STUFF_RUN = 3'h5;
  localparam logic [3:0]  MAX_DLC   = 4'h8;
  localparam logic [14:0] CRC_POLY  = 15'h4599;

  typedef struct packed {
    logic [3:0] first_segment_length;
    logic [2:0] second_segment_length;
    logic [1:0] resync_jump_width;
    logic [7:0] quantum_prescaler;
  } cbtrs_timing_t;

  typedef enum {ST_IDLE, ST_HDR, ST_DATA, ST_CRC, ST_TAIL} cbtrs_state_t;
endpackage

// ### cbtrs_top.sv
// bit timing, bus join sequencing and standard data frame receive
// assumes CAN_RX comes from a transceiver pin, wishbone on CLK
//
// Function
// R1: bit is sync, propagation, phase one, phase two
// R2: segment lengths equal field value plus one
// R3: quantum lasts two times prescaler plus one
// R4: software keeps segment one above segment two
// R5: software keeps bit length 8 to 25 quanta
// R6: resync shifts phase by at most jump width
// R7: configure in reset mode, join after release
// R8: 31 mailboxes, one receive-only, one mask (the code has NUM_MB = 32 by default)
// R9: mode bit 0 enters or leaves reset mode
// R10: direction code 010 enables mailbox receive
// R11: writing one clears a receive pending flag
// R12: matching frame stored, pending flag set
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module cbtrs_top #(
  parameter int NUM_MB = 32
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [31:0] WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic        WB_WE_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  output logic             IRQ,
  input  wire logic        CAN_RX,
  output logic             CAN_TX
);
  localparam int IW = 5;
  if (NUM_MB < 2 || NUM_MB > 32) begin : g_bad_num_mb
    $error("NUM_MB must lie in 2..32");
  end

  logic                  req, wr, mb_hit, hit, frame_ok;
  logic [11:0]           adr, mb_off;
  logic [IW-1:0]         mb_idx, hit_idx;
  logic [2:0]            mb_w;
  logic [31:0]           wmask, rd_d, up_word;
  logic [15:0]           up_new;
  logic                  mode_q, bus_on_q;
  cbtrs_pkg::cbtrs_timing_t tim_q;
  logic [10:0]           mask_q;
  logic [NUM_MB-1:0]     pend_q, irq_en_q, pend_set, pend_clr;
  logic [10:0]           mb_id   [NUM_MB];
  logic [2:0]            mb_dir  [NUM_MB];
  logic [3:0]            mb_dlc  [NUM_MB];
  logic [63:0]           mb_data [NUM_MB];
  cbtrs_pkg::cbtrs_state_t st_q;
  logic [6:0]            cnt_q;
  logic [17:0]           hdr_q;
  logic [63:0]           data_q;
  logic [14:0]           crc_q, crc_nx;
  logic [2:0]            run_q;
  logic [3:0]            idle_cnt_q, dlc_eff;
  logic                  last_q, rx;

  assign adr    = WB_ADR_I[11:0];
  assign req    = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign wr     = req & WB_WE_I;
  assign wmask  = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                   {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  assign mb_off = adr - cbtrs_pkg::OFF_MB_BASE;
  assign mb_hit = adr >= cbtrs_pkg::OFF_MB_BASE
                  && 32'(mb_off[11:5]) < NUM_MB;
  assign mb_idx = mb_off[IW+4:5];
  assign mb_w   = mb_off[4:2];
  assign up_word = {16'h0000, tim_q.first_segment_length, 1'b0, tim_q.second_segment_length, 2'b00,
                    tim_q.resync_jump_width, 4'h0};
  assign up_new = (up_word[15:0] & ~wmask[15:0])
                  | (WB_DAT_I[15:0] & wmask[15:0]);

  // a single-cycle answer: ack one edge after the request is seen
  always_ff @(posedge CLK) begin
    if (RST) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= req;
      if (req) begin
        WB_DAT_O <= rd_d;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      mode_q <= cbtrs_pkg::MODE_RST;
    end else if (wr && adr == cbtrs_pkg::OFF_MODE && WB_SEL_I[0]) begin
      mode_q <= WB_DAT_I[0]; // [R9]
    end
  end

  // timing is frozen outside reset mode so a live bit never changes shape
  always_ff @(posedge CLK) begin
    if (RST) begin
      tim_q.first_segment_length <= cbtrs_pkg::TIMING_UP_RST[cbtrs_pkg::FIRST_SEGMENT_LENGTH_LSB+:4];
      tim_q.second_segment_length <= cbtrs_pkg::TIMING_UP_RST[cbtrs_pkg::SECOND_SEGMENT_LENGTH_LSB+:3];
      tim_q.resync_jump_width   <= cbtrs_pkg::TIMING_UP_RST[cbtrs_pkg::SJW_LSB+:2];
      tim_q.quantum_prescaler   <= cbtrs_pkg::PRESCALE_RST;
    end else if (wr && mode_q) begin // [R7]
      if (adr == cbtrs_pkg::OFF_TIMING_UP) begin
        tim_q.first_segment_length <= up_new[cbtrs_pkg::FIRST_SEGMENT_LENGTH_LSB+:4]; // [R2]
        tim_q.second_segment_length <= up_new[cbtrs_pkg::SECOND_SEGMENT_LENGTH_LSB+:3]; // [R2]
        tim_q.resync_jump_width   <= up_new[cbtrs_pkg::SJW_LSB+:2];
      end
      if (adr == cbtrs_pkg::OFF_TIMING_LO && WB_SEL_I[0]) begin
        tim_q.quantum_prescaler <= WB_DAT_I[7:0]; // [R3]
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      mask_q   <= '0;
      irq_en_q <= '0;
    end else if (wr) begin
      if (adr == cbtrs_pkg::OFF_MASK) begin
        mask_q <= (mask_q & ~wmask[10:0]) | (WB_DAT_I[10:0] & wmask[10:0]);
      end
      if (adr == cbtrs_pkg::OFF_IRQ_EN) begin
        irq_en_q <= (irq_en_q & ~wmask[NUM_MB-1:0])
                    | (WB_DAT_I[NUM_MB-1:0] & wmask[NUM_MB-1:0]);
      end
    end
  end

  // a frame landing in the same cycle as a clear keeps its flag
  assign pend_clr = (wr && (adr == cbtrs_pkg::OFF_PEND
                            || adr == cbtrs_pkg::OFF_PEND_CLR))
                    ? WB_DAT_I[NUM_MB-1:0] & wmask[NUM_MB-1:0] : '0;
  assign pend_set = (frame_ok && hit) ? NUM_MB'(1) << hit_idx : '0;
  always_ff @(posedge CLK) begin
    if (RST) begin
      pend_q <= '0;
      IRQ    <= 1'b0;
    end else begin
      pend_q <= (pend_q & ~pend_clr) | pend_set; // [R11] [R12]
      IRQ    <= |(pend_q & irq_en_q);
    end
  end

  // mailbox store; the receiver wins a same-cycle collision with the bus
  always_ff @(posedge CLK) begin
    if (RST) begin
      for (int i = 0; i < NUM_MB; i++) begin
        mb_id[i]   <= '0;
        mb_dir[i]  <= cbtrs_pkg::DIR_TX;
        mb_dlc[i]  <= '0;
        mb_data[i] <= '0;
      end
    end else begin
      if (wr && mb_hit) begin
        unique case (mb_w)
          cbtrs_pkg::MBW_ID:  mb_id[mb_idx] <= WB_DAT_I[10:0];
          cbtrs_pkg::MBW_CFG: begin
            mb_dir[mb_idx] <= WB_DAT_I[cbtrs_pkg::DIR_LSB+:3];
            mb_dlc[mb_idx] <= WB_DAT_I[3:0];
          end
          cbtrs_pkg::MBW_DLO: mb_data[mb_idx][63:32] <= WB_DAT_I;
          cbtrs_pkg::MBW_DHI: mb_data[mb_idx][31:0] <= WB_DAT_I;
          default: ;
        endcase
      end
      if (frame_ok && hit) begin // [R12]
        mb_id[hit_idx]   <= hdr_q[17:7];
        mb_dlc[hit_idx]  <= hdr_q[3:0];
        mb_data[hit_idx] <= data_q << {cbtrs_pkg::MAX_DLC - dlc_eff, 3'b000};
      end
    end
  end

  function automatic logic [2:0] dir_of(input int i);
    return (i == NUM_MB - 1) ? cbtrs_pkg::DIR_RX : mb_dir[i]; // [R8]
  endfunction

  always_comb begin
    rd_d = 32'h0000_0000;
    case (adr)
      cbtrs_pkg::OFF_MODE:      rd_d[0] = mode_q;
      cbtrs_pkg::OFF_TIMING_UP: rd_d = up_word;
      cbtrs_pkg::OFF_TIMING_LO: rd_d[7:0] = tim_q.quantum_prescaler;
      cbtrs_pkg::OFF_STATUS:
        rd_d[2:0] = {st_q != cbtrs_pkg::ST_IDLE, bus_on_q, mode_q};
      cbtrs_pkg::OFF_PEND:      rd_d[NUM_MB-1:0] = pend_q;
      cbtrs_pkg::OFF_IRQ_EN:    rd_d[NUM_MB-1:0] = irq_en_q;
      cbtrs_pkg::OFF_MASK:      rd_d[10:0] = mask_q;
      default: if (mb_hit) begin
        case (mb_w)
          cbtrs_pkg::MBW_ID:  rd_d[10:0] = mb_id[mb_idx];
          cbtrs_pkg::MBW_CFG: begin
            rd_d[cbtrs_pkg::DIR_LSB+:3] = dir_of(32'(mb_idx));
            rd_d[3:0] = mb_dlc[mb_idx];
          end
          cbtrs_pkg::MBW_DLO: rd_d = mb_data[mb_idx][63:32];
          cbtrs_pkg::MBW_DHI: rd_d = mb_data[mb_idx][31:0];
          default: rd_d = 32'h0000_0000;
        endcase
      end
    endcase
  end

  // quantum clock and bit segments
  logic [9:0] presc_q, period;
  logic [5:0] pos_q, seg1_end_q, bit_end_q, t1, t2, sjwv, ext, rem;
  logic       tick, sample, boundary, rx_s1_q, rx_s2_q, rx_prev_q, edge_q;
  assign period   = {1'b0, tim_q.quantum_prescaler, 1'b0} + 10'h002; // [R3]
  assign tick     = presc_q == period - 10'h001;
  assign t1       = 6'(tim_q.first_segment_length) + 6'h01; // [R2]
  assign t2       = 6'(tim_q.second_segment_length) + 6'h01; // [R2]
  assign sjwv     = 6'(tim_q.resync_jump_width) + 6'h01;
  assign ext      = (pos_q < sjwv) ? pos_q : sjwv;
  assign rem      = bit_end_q - pos_q;
  assign sample   = tick && pos_q == seg1_end_q && !mode_q;
  assign boundary = tick && pos_q == bit_end_q;

  always_ff @(posedge CLK) begin
    if (RST || mode_q) begin
      presc_q <= '0;
    end else begin
      presc_q <= tick ? 10'h000 : presc_q + 10'h001; // [R3]
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      rx_s1_q   <= 1'b1;
      rx_s2_q   <= 1'b1;
      rx_prev_q <= 1'b1;
      edge_q    <= 1'b0;
    end else begin
      rx_s1_q   <= CAN_RX;
      rx_s2_q   <= rx_s1_q;
      rx_prev_q <= rx_s2_q;
      if (rx_prev_q && !rx_s2_q) begin
        edge_q <= 1'b1;
      end else if (tick) begin
        edge_q <= 1'b0;
      end
    end
  end

  // pos 0 is the sync quantum, phase one ends at seg1_end_q (sample)
  always_ff @(posedge CLK) begin
    if (RST || mode_q) begin
      pos_q      <= '0;
      seg1_end_q <= t1;
      bit_end_q  <= t1 + t2; // [R1]
    end else if (tick) begin
      if (edge_q && (st_q == cbtrs_pkg::ST_IDLE || rem < sjwv)) begin
        pos_q      <= 6'h01; // hard sync, or edge taken as next sync
        seg1_end_q <= t1;
        bit_end_q  <= t1 + t2;
      end else if (edge_q && pos_q != 6'h00 && pos_q <= seg1_end_q) begin
        seg1_end_q <= seg1_end_q + ext; // [R6]
        bit_end_q  <= bit_end_q + ext;
        pos_q      <= pos_q + 6'h01;
      end else if (edge_q && pos_q > seg1_end_q && rem > sjwv) begin
        bit_end_q <= bit_end_q - sjwv; // [R6]
        pos_q     <= pos_q + 6'h01;
      end else if (boundary || (edge_q && pos_q > seg1_end_q)) begin
        pos_q      <= 6'h00; // [R1]
        seg1_end_q <= t1;
        bit_end_q  <= t1 + t2;
      end else begin
        pos_q <= pos_q + 6'h01;
      end
    end
  end

  // frame receive
  assign rx      = rx_s2_q;
  assign crc_nx  = {crc_q[13:0], 1'b0}
                   ^ ((rx ^ crc_q[14]) ? cbtrs_pkg::CRC_POLY : 15'h0000);
  assign dlc_eff = (hdr_q[3:0] > cbtrs_pkg::MAX_DLC) ? cbtrs_pkg::MAX_DLC
                                                     : hdr_q[3:0];
  assign frame_ok = sample && st_q == cbtrs_pkg::ST_TAIL
                    && cnt_q == cbtrs_pkg::TAIL_LAST && rx
                    && crc_q == 15'h0000 && !hdr_q[6] && !hdr_q[5]; // [R12]

  always_ff @(posedge CLK) begin
    if (RST || mode_q) begin // [R7]
      st_q       <= cbtrs_pkg::ST_IDLE;
      bus_on_q   <= 1'b0;
      idle_cnt_q <= '0;
      cnt_q      <= '0;
      run_q      <= '0;
      last_q     <= 1'b1;
      crc_q      <= '0;
      hdr_q      <= '0;
      data_q     <= '0;
    end else if (sample) begin
      unique case (st_q)
        cbtrs_pkg::ST_IDLE: begin
          // a start bit counts only once the hard sync has realigned
          if (!rx && bus_on_q && !edge_q && !rx_prev_q) begin
            st_q   <= cbtrs_pkg::ST_HDR;
            cnt_q  <= '0;
            crc_q  <= '0;
            run_q  <= 3'h1;
            last_q <= 1'b0;
            data_q <= '0;
          end else if (!rx) begin
            idle_cnt_q <= '0;
          end else if (!bus_on_q) begin
            idle_cnt_q <= idle_cnt_q + 4'h1;
            // join only after a run of recessive bits
            bus_on_q   <= idle_cnt_q == cbtrs_pkg::IDLE_BITS - 4'h1; // [R7]
          end
        end
        cbtrs_pkg::ST_TAIL: begin
          if (cnt_q == 7'h00 && run_q == cbtrs_pkg::STUFF_RUN) begin
            // the crc may end in a stuff bit; drop it before the delimiter
            run_q <= 3'h1;
            if (rx == last_q) begin
              st_q <= cbtrs_pkg::ST_IDLE;
            end
          end else begin
            cnt_q <= cnt_q + 7'h01;
            if (cnt_q == cbtrs_pkg::TAIL_LAST
                || (!rx && cnt_q != cbtrs_pkg::ACK_SLOT)) begin
              st_q <= cbtrs_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          if (run_q == cbtrs_pkg::STUFF_RUN) begin
            // stuff bit: dropped; a sixth equal bit aborts the frame
            run_q  <= 3'h1;
            last_q <= rx;
            if (rx == last_q) begin
              st_q <= cbtrs_pkg::ST_IDLE;
            end
          end else begin
            run_q  <= (rx == last_q) ? run_q + 3'h1 : 3'h1;
            last_q <= rx;
            crc_q  <= crc_nx;
            cnt_q  <= cnt_q + 7'h01;
            if (st_q == cbtrs_pkg::ST_HDR) begin
              hdr_q <= {hdr_q[16:0], rx};
              if (cnt_q == cbtrs_pkg::HDR_LAST) begin
                cnt_q <= '0;
                st_q  <= ({hdr_q[2:0], rx} == 4'h0) ? cbtrs_pkg::ST_CRC
                                                   : cbtrs_pkg::ST_DATA;
              end
            end else if (st_q == cbtrs_pkg::ST_DATA) begin
              data_q <= {data_q[62:0], rx};
              if (cnt_q == {dlc_eff, 3'b000} - 7'h01) begin
                cnt_q <= '0;
                st_q  <= cbtrs_pkg::ST_CRC;
              end
            end else if (cnt_q == cbtrs_pkg::CRC_LAST) begin
              cnt_q <= '0;
              st_q  <= cbtrs_pkg::ST_TAIL;
            end
          end
        end
      endcase
    end
  end

  // acceptance: lowest receive-enabled mailbox whose unmasked id matches
  always_comb begin
    hit     = 1'b0;
    hit_idx = '0;
    for (int i = NUM_MB - 1; i >= 0; i--) begin
      if (dir_of(i) == cbtrs_pkg::DIR_RX // [R10]
          && ((mb_id[i] ^ hdr_q[17:7]) & ~mask_q) == 11'h000) begin
        hit     = 1'b1;
        hit_idx = IW'(i);
      end
    end
  end

  // acknowledge a frame with good crc for the whole ack slot
  always_ff @(posedge CLK) begin
    if (RST || mode_q) begin
      CAN_TX <= 1'b1;
    end else if (boundary) begin
      CAN_TX <= !(st_q == cbtrs_pkg::ST_TAIL
                  && cnt_q == cbtrs_pkg::ACK_SLOT && crc_q == 15'h0000);
    end
  end

  logic [9:0] gap_q;
  always_ff @(posedge CLK) begin
    if (RST || mode_q) begin
      gap_q <= '0;
    end else begin
      gap_q <= tick ? 10'h000 : gap_q + 10'h001;
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  chk_quantum_len: assert property (tick |-> // [R3]
    32'(gap_q) + 1 == 2 * (32'(tim_q.quantum_prescaler) + 1))
    else $error("quantum length wrong");
  chk_seg_lengths: assert property ((boundary && !edge_q && !mode_q) |=> // [R2]
    seg1_end_q == 6'(tim_q.first_segment_length) + 6'h01
    && bit_end_q == 6'(tim_q.first_segment_length) + 6'(tim_q.second_segment_length) + 6'h02)
    else $error("segment lengths wrong");
  chk_bit_order: assert property (!mode_q |-> // [R1]
    pos_q <= bit_end_q && seg1_end_q < bit_end_q && seg1_end_q >= 6'h01)
    else $error("bit segments out of order");
  chk_resync_width: assert property (!mode_q |-> // [R6]
    seg1_end_q <= t1 + sjwv && bit_end_q - seg1_end_q >= t2 - sjwv
    && bit_end_q - seg1_end_q <= t2)
    else $error("resync beyond jump width");
  chk_reset_hold: assert property (mode_q |=> // [R7]
    st_q == cbtrs_pkg::ST_IDLE && !bus_on_q && CAN_TX
    || !$past(mode_q))
    else $error("bus activity in reset mode");
  chk_timing_frozen: assert property (!mode_q && !$past(mode_q) |-> // [R7]
    $stable(tim_q))
    else $error("timing changed outside reset mode");
  chk_mode_write: assert property ((wr && adr == cbtrs_pkg::OFF_MODE // [R9]
    && WB_SEL_I[0]) |=> mode_q == $past(WB_DAT_I[0]) ##1 WB_ACK_O == 1'b0)
    else $error("mode bit not taken");
  chk_rx_only_mb: assert property ((req && !WB_WE_I && mb_hit // [R8]
    && mb_idx == IW'(NUM_MB - 1) && mb_w == cbtrs_pkg::MBW_CFG) |=>
    WB_DAT_O[cbtrs_pkg::DIR_LSB+:3] == cbtrs_pkg::DIR_RX)
    else $error("last mailbox not receive-only");
  chk_rx_enable: assert property ((frame_ok && hit) |-> // [R10]
    dir_of(32'(hit_idx)) == cbtrs_pkg::DIR_RX)
    else $error("stored into a non-receive mailbox");
  chk_pend_clear: assert property ((pend_clr != '0 && pend_set == '0) |=> // [R11]
    (pend_q & $past(pend_clr)) == '0)
    else $error("pending flag not cleared");
  chk_store_pend: assert property ((frame_ok && hit) |=> // [R12]
    pend_q[$past(hit_idx)] && mb_id[$past(hit_idx)] == $past(hdr_q[17:7])
    && mb_dlc[$past(hit_idx)] == $past(hdr_q[3:0]))
    else $error("frame not stored");
  chk_bus_answer: assert property (req |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("wishbone answer not single cycle");
endmodule // cbtrs_top

// ### cbtrs_top_tb.sv
// self-checking bench: wishbone host, remote node and a reference model
// assumes cbtrs_top with its default 32 mailboxes and cbtrs_can_node
`timescale 1ns/1ps
`define CHK(what, exp, got) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("BAD %s exp %h got %h", what, exp, got); \
  end \
end
module cbtrs_top_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] adr = '0;
  logic [31:0] dat = '0;
  logic [3:0]  sel = 4'hF;
  logic        we = 1'b0;
  logic        stb = 1'b0;
  logic [31:0] dat_o;
  logic        ack;
  logic        irq;
  logic        can_tx;
  logic        node_tx;
  logic        node_ack;
  wire         can_bus = node_tx & can_tx;
  int          num_errors = 0;
  int          total_checks = 0;
  int          cycles = 0;
  logic [10:0] mb_id [32];
  logic [2:0]  mb_dir [32];
  logic [31:0] pend = '0;
  logic [10:0] mask = '0;
  logic [31:0] rd;
  logic [31:0] up;
  logic [10:0] ids [5] = '{11'h2A5, 11'h13C, 11'h7F0, 11'h055, 11'h2A0};
  // timing table keeps segment one above segment two
  int quantum_prescaler [5] = '{0, 2, 0, 0, 0};
  int t1 [5] = '{9, 4, 3, 9, 15};
  int t2 [5] = '{6, 2, 2, 6, 7};
  int resync_jump_width [5] = '{0, 0, 1, 3, 3};
  int drift [5] = '{0, 0, 0, -1, 1};

  always #5 clk = ~clk;

  cbtrs_top uut (.CLK(clk), .RST(rst), .WB_ADR_I(adr), .WB_DAT_I(dat),
    .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(stb), .WB_STB_I(stb),
    .WB_DAT_O(dat_o), .WB_ACK_O(ack), .IRQ(irq), .CAN_RX(can_bus),
    .CAN_TX(can_tx));

  cbtrs_can_node node (.clk(clk), .can_bus(can_bus), .node_tx(node_tx),
    .ack_seen(node_ack));

  task automatic stop_test();
    if (num_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      stop_test();
    end
  end

  function automatic logic [11:0] mba(input int n);
    return cbtrs_pkg::OFF_MB_BASE + 12'(n * 32);
  endfunction

  task automatic wb(input logic w, input logic [11:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    adr <= {20'h00000, a};
    dat <= d;
    we <= w;
    stb <= 1'b1;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_o;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp,
                       input logic [31:0] m, input string what);
    wb(1'b0, a, 32'h0);
    `CHK(what, exp & m, rd & m)
  endtask

  task automatic frame(input logic [10:0] id, input bit bad, input bit on);
    logic [63:0] d;
    logic [63:0] keep;
    logic [3:0]  dlc;
    logic [11:0] base;
    int          hit;
    d = {$urandom, $urandom};
    dlc = 4'($urandom_range(15, 0));
    keep = ~(64'hFFFF_FFFF_FFFF_FFFF >> ((dlc > 4'h8 ? 8 : int'(dlc)) * 8));
    hit = -1;
    node.send(id, dlc, d, bad);
    for (int i = 31; i >= 0; i--) begin
      if (on && !bad && mb_dir[i] == cbtrs_pkg::DIR_RX &&
          ((id ^ mb_id[i]) & ~mask) == 11'h000) hit = i;
    end
    `CHK("ack", 1'(on && !bad), node_ack)
    rdchk(cbtrs_pkg::OFF_STATUS, {30'h0, on, 1'b0}, 32'h6, "joined");
    if (hit >= 0) begin
      pend[hit] = 1'b1;
      base = mba(hit);
      rdchk(base, {21'h0, id}, '1, "id");
      rdchk(base + 12'h4, {21'h0, mb_dir[hit], 4'h0, dlc}, '1, "dlc");
      rdchk(base + 12'h8, d[63:32], keep[63:32], "lo");
      rdchk(base + 12'hC, d[31:0], keep[31:0], "hi");
    end
    rdchk(cbtrs_pkg::OFF_PEND, pend, '1, "pending");
    `CHK("irq", |(pend & 32'h5), irq)
    if (hit >= 0) begin
      wb(1'b1, hit[0] ? cbtrs_pkg::OFF_PEND : cbtrs_pkg::OFF_PEND_CLR, pend);
      pend = '0;
      rdchk(cbtrs_pkg::OFF_PEND, pend, '1, "cleared");
      `CHK("irq off", 1'b0, irq)
    end
  endtask

  initial begin
    rd = $urandom(32'h7954);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    rdchk(cbtrs_pkg::OFF_MODE, 32'h1, '1, "mode");
    rdchk(cbtrs_pkg::OFF_TIMING_UP, 32'h9600, '1, "timing");
    rdchk(cbtrs_pkg::OFF_TIMING_LO, 32'h0, '1, "prescale");
    rdchk(cbtrs_pkg::OFF_STATUS, 32'h1, 32'h3, "status");
    rdchk(12'h040, 32'h0, '1, "unmapped");
    for (int i = 0; i < 32; i++) begin
      mb_id[i] = (i == 2) ? ids[1] : (i == 31) ? ids[2] : ids[0];
      mb_dir[i] = (i == 0 || i == 2 || i == 31) ? 3'h2 : 3'h0;
      wb(1'b1, mba(i), {21'h0, mb_id[i]});
      wb(1'b1, mba(i) + 12'h4, (i == 31) ? 32'h0 : {21'h0, mb_dir[i], 8'h0});
    end
    rdchk(mba(31) + 12'h4, 32'h200, 32'h700, "rx only");
    sel <= 4'h1;
    wb(1'b1, cbtrs_pkg::OFF_IRQ_EN, 32'hFFFF_FF05);
    sel <= 4'hF;
    rdchk(cbtrs_pkg::OFF_IRQ_EN, 32'h5, '1, "irq enable");
    frame(ids[0], 1'b0, 1'b0);
    for (int k = 0; k < 5; k++) begin
      wb(1'b1, cbtrs_pkg::OFF_MODE, 32'h1);
      up = {16'h0, 4'(t1[k]), 1'b0, 3'(t2[k]), 2'b00, 2'(resync_jump_width[k]), 4'h0};
      wb(1'b1, cbtrs_pkg::OFF_TIMING_UP, up);
      wb(1'b1, cbtrs_pkg::OFF_TIMING_LO, {24'h0, 8'(quantum_prescaler[k])});
      mask = (k == 4) ? 11'h00F : 11'h000;
      wb(1'b1, cbtrs_pkg::OFF_MASK, {21'h0, mask});
      rdchk(cbtrs_pkg::OFF_TIMING_UP, up, '1, "timing set");
      wb(1'b1, cbtrs_pkg::OFF_MODE, 32'h0);
      wb(1'b1, cbtrs_pkg::OFF_TIMING_UP, 32'h0);
      rdchk(cbtrs_pkg::OFF_TIMING_UP, up, '1, "locked");
      rdchk(cbtrs_pkg::OFF_STATUS, 32'h0, 32'h1, "mode off");
      node.bit_clks = 2 * (quantum_prescaler[k] + 1) * (t1[k] + t2[k] + 3) + drift[k];
      frame(ids[k], 1'b0, 1'b1);
    end
    frame(ids[0], 1'b1, 1'b1);
    stop_test();
  end
endmodule // cbtrs_top_tb
